/* pkg/irq_arb_consts.svh */
// Constants for the interrupt and trap priority arbiter.
// Assumes byte addressing on a 32-bit register bus, one word per register.
`ifndef IRQ_ARB_CONSTS_SVH
`define IRQ_ARB_CONSTS_SVH

// Sources, priority fields and vectors
`define IRQ_NUM_SRC 54
`define IRQ_SRC_W 6
`define IRQ_FIELD_W 3
`define IRQ_NIB_W 4
`define IRQ_NIBS_PER_REG 4
`define IRQ_VECTOR_BASE 8'h08
`define IRQ_PRIO_RESET 3'h0

// Trap levels and priority thresholds
`define IRQ_MATH_TRAP_LEVEL 4'hB
`define IRQ_ADDR_TRAP_LEVEL 4'hC
`define IRQ_BLOCK_ALL_LEVEL 4'h7

// Reset entry fetch
`define IRQ_RESET_PC 24'h000000
`define IRQ_PROG_WORD_STEP 24'h000001

// Register byte offsets
`define IRQ_PRIO_BASE 8'h00
`define IRQ_PRIO_REG_COUNT 14
`define IRQ_FLAGS_LO 8'h40
`define IRQ_FLAGS_HI 8'h44
`define IRQ_ENABLE_LO 8'h48
`define IRQ_ENABLE_HI 8'h4C
`define IRQ_CTRL 8'h50
`define IRQ_STATUS 8'h54

// Control fields and reset value
`define IRQ_CTRL_OVF31_EN 0
`define IRQ_CTRL_OVF39_EN 1
`define IRQ_CTRL_RESET 2'h0

// Status fields
`define IRQ_ST_IPL_LSB 0
`define IRQ_ST_MATH_BIT 4
`define IRQ_ST_ADDR_BIT 5
`define IRQ_ST_CAUSE_LSB 8
`define IRQ_ST_VEC_LSB 16

// Reset cause bits
`define IRQ_CAUSE_WATCHDOG 0
`define IRQ_CAUSE_UNINIT_W 1
`define IRQ_CAUSE_ILLEGAL 2
`define IRQ_CAUSE_BROWNOUT 3
`define IRQ_CAUSE_LOCKOUT 4
`define IRQ_CAUSE_CONFLICT 5
`define IRQ_CAUSE_COUNT 6

`endif

/* pkg/irq_arb_pkg.sv */
// Types shared by the interrupt and trap priority arbiter.
// Assumes irq_arb_consts.svh is on the include path.
`default_nettype none
`include "irq_arb_consts.svh"

package irq_arb_pkg;

	// Reset entry sequence states
	typedef enum logic [1:0] {
		ENTRY_OPCODE = 2'b00,
		ENTRY_TARGET = 2'b01,
		ENTRY_RUN = 2'b10
	} entry_state_t;

	// Avalon-MM request from the master
	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} avalon_req_t;

	// Trap conditions reported by the core, one cycle each
	typedef struct packed {
		logic div_by_zero;
		logic acc_ovf31;
		logic guard_bits_used;
		logic acc_ovf39;
		logic saturation_off;
		logic shift_too_big;
		logic misaligned_word;
		logic unimpl_data_read;
		logic unimpl_prog_access;
		logic fetch_vector_space;
		logic flow_to_unimpl;
		logic invalid_vector;
	} trap_cond_t;

	// Error conditions that end in a forced reset, and the opcode flush that cancels an illegal one
	typedef struct packed {
		logic watchdog_timeout;
		logic uninit_w_pointer;
		logic illegal_exec;
		logic opcode_flushed;
		logic brownout_reset;
	} reset_err_t;

	// Request presented to the core
	typedef struct packed {
		logic valid;
		logic is_trap;
		logic [3:0] level;
		logic [7:0] vector;
	} core_req_t;

	// Source number to vector number
	function automatic logic [7:0] irq_vector(input logic [`IRQ_SRC_W-1:0] src);
		irq_vector = {2'b00, src} + `IRQ_VECTOR_BASE;
	endfunction : irq_vector

	// Byte enables widened to a bit mask
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : be_mask

endpackage : irq_arb_pkg

`default_nettype wire

/* rtl/irq_level_picker.sv */
// Combinational winner search over pending interrupt sources.
// Assumes pending bits are already gated by their enables.
`default_nettype none
`include "irq_arb_consts.svh"

module irq_level_picker
	import irq_arb_pkg::*;
#(
	parameter int NUM_SRC = `IRQ_NUM_SRC
) (
	input wire logic [NUM_SRC-1:0] pending_in,
	input wire logic [NUM_SRC-1:0][`IRQ_FIELD_W-1:0] prio_in,
	output logic found_out,
	output logic [`IRQ_SRC_W-1:0] src_out,
	output logic [`IRQ_FIELD_W-1:0] level_out
);

	// Scan from the last source down, so a tie goes to the lower number
	always_comb begin
		found_out = 1'b0;
		src_out = '0;
		level_out = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (pending_in[i] && prio_in[i] != '0 && prio_in[i] >= level_out) begin
				found_out = 1'b1;
				src_out = `IRQ_SRC_W'(i);
				level_out = prio_in[i];
			end
		end
	end

endmodule : irq_level_picker

`default_nettype wire

/* rtl/irq_trap_priority_arbiter.sv */
// Interrupt and trap priority arbiter with reset entry sequencer.
// Assumes an Avalon-MM master, a core that reports trap conditions and
// instruction boundaries, and peripherals that pulse their events.
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`default_nettype none
`include "irq_arb_consts.svh"

// Overview of operation
// - Each source priority is a three-bit field in the low bits of a nibble.
// - The top bit of each priority nibble is unimplemented and reads zero.
// - Level zero ranks lowest, level seven ranks highest.
// - Natural order only breaks ties among equal-level requests pending together.
// - Natural order follows source number; source 0 wins, source 53 loses.
// - Vector number equals source number plus eight.
// - After reset, program fetching starts at address zero.
// - First word holds an absolute jump; the next word holds its target.
// - Six error conditions besides external and power-on reset force a reset.
// - An unused opcode flushed before execution raises no illegal trap.
// - Using an unwritten working register as pointer forces a reset.
// - A math and an address trap condition at once force a reset.
// - Traps are non-maskable with fixed priority software cannot change.
// - The trapping instruction completes before trap processing begins.
// - Traps occupy levels eight to fifteen, so the priority top bit is set.
// - Processor priority 0111 blocks every interrupt but still admits traps.
// - Divide by zero aborts the divide and takes the math error trap.
// - Enabled accumulator overflows from bit 31 or bit 39 take the math trap.
// - An oversize shift request takes the math error trap.
// - Misaligned, unimplemented or vector-space accesses take the address trap.
// - Flow changes to unimplemented program memory take the address trap.
// - Using a vector that holds an invalid address takes the address trap.
// - Interrupt only for enabled pending level strictly above processor priority.
// - A source at level zero is disabled and never interrupts.
module irq_trap_priority_arbiter
	import irq_arb_pkg::*;
#(
	parameter logic [7:0] MATH_TRAP_VECTOR = 8'h01,
	parameter logic [7:0] ADDR_TRAP_VECTOR = 8'h02
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire avalon_req_t avs_req_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic [`IRQ_NUM_SRC-1:0] irq_event_in,
	input wire logic [3:0] cpu_priority_bits_in,
	input wire logic instr_done_in,
	input wire logic take_in,
	input wire trap_cond_t trap_cond_in,
	input wire reset_err_t reset_err_in,
	input wire logic fetch_valid_in,
	input wire logic [23:0] fetch_data_in,
	output core_req_t core_req_out,
	output logic force_reset_out,
	output logic div_abort_out,
	output logic fetch_req_out,
	output logic [23:0] fetch_addr_out,
	output logic start_valid_out,
	output logic [23:0] start_pc_out
);

	localparam int NSRC = `IRQ_NUM_SRC;
	localparam int HI_W = NSRC - 32;

	// Complete block state
	typedef struct packed {
		logic [NSRC-1:0][`IRQ_FIELD_W-1:0] prio;
		logic [NSRC-1:0] flags;
		logic [NSRC-1:0] enables;
		logic [1:0] ctrl;
		logic [`IRQ_CAUSE_COUNT-1:0] cause;
		logic math_pend;
		logic addr_pend;
		logic trap_ready;
		logic ack;
		logic [31:0] readdata;
		core_req_t req;
		logic [`IRQ_SRC_W-1:0] win_src;
		logic force_reset;
		logic div_abort;
		entry_state_t entry;
		logic fetch_req;
		logic [23:0] fetch_addr;
		logic start_valid;
		logic [23:0] start_pc;
	} arb_state_t;

	arb_state_t st;
	arb_state_t next_st;

	logic win_found;
	logic [`IRQ_SRC_W-1:0] win_src;
	logic [`IRQ_FIELD_W-1:0] win_level;
	logic math_cond;
	logic addr_cond;
	logic lockout;

	// Winner among enabled pending flags
	irq_level_picker #(
		.NUM_SRC(NSRC)
	) i_irq_level_picker (
		.pending_in(st.flags & st.enables),
		.prio_in(st.prio),
		.found_out(win_found),
		.src_out(win_src),
		.level_out(win_level)
	);

	// Trap condition decode; only the overflow conditions pass through the control enables
	always_comb begin
		math_cond = trap_cond_in.div_by_zero
			| (trap_cond_in.acc_ovf31 & ~trap_cond_in.guard_bits_used
				& st.ctrl[`IRQ_CTRL_OVF31_EN])
			| (trap_cond_in.acc_ovf39 & trap_cond_in.saturation_off
				& st.ctrl[`IRQ_CTRL_OVF39_EN])
			| trap_cond_in.shift_too_big;
		addr_cond = trap_cond_in.misaligned_word | trap_cond_in.unimpl_data_read
			| trap_cond_in.unimpl_prog_access | trap_cond_in.fetch_vector_space
			| trap_cond_in.flow_to_unimpl
			| trap_cond_in.invalid_vector;
		lockout = math_cond & addr_cond;
	end

	// Next state
	always_comb begin
		logic [31:0] mask;
		logic [31:0] rd;
		logic wr;
		logic take_trap;
		logic [31:0] clr_lo;
		logic [31:0] clr_hi;
		logic [`IRQ_CAUSE_COUNT-1:0] cause_set;
		logic [`IRQ_CAUSE_COUNT-1:0] cause_clr;
		int src;
		mask = be_mask(avs_req_in.byteenable);
		rd = '0;
		wr = avs_req_in.write && st.ack;
		take_trap = take_in && st.req.valid && st.req.is_trap;
		clr_lo = '0;
		clr_hi = '0;
		cause_set = '0;
		cause_clr = '0;
		src = 0;
		next_st = st;

		// Bus handshake: one wait cycle, then an ack cycle
		next_st.ack = (avs_req_in.read || avs_req_in.write) && !st.ack;

		// Read decode; unmapped offsets read zero
		if (avs_req_in.address < `IRQ_PRIO_BASE + 8'(4 * `IRQ_PRIO_REG_COUNT)) begin
			for (int j = 0; j < `IRQ_NIBS_PER_REG; j++) begin
				// Word index times four plus nibble gives the source
				src = int'(avs_req_in.address[7:2]) * `IRQ_NIBS_PER_REG + j;
				if (src < NSRC) begin
					rd[j*`IRQ_NIB_W +: `IRQ_FIELD_W] = st.prio[src];
				end
			end
		end else begin
			unique case (avs_req_in.address)
				`IRQ_FLAGS_LO: rd = st.flags[31:0];
				`IRQ_FLAGS_HI: rd = {{(32-HI_W){1'b0}}, st.flags[NSRC-1:32]};
				`IRQ_ENABLE_LO: rd = st.enables[31:0];
				`IRQ_ENABLE_HI: rd = {{(32-HI_W){1'b0}}, st.enables[NSRC-1:32]};
				`IRQ_CTRL: rd = {30'h0, st.ctrl};
				`IRQ_STATUS: begin
					rd[`IRQ_ST_IPL_LSB +: 4] = cpu_priority_bits_in;
					rd[`IRQ_ST_MATH_BIT] = st.math_pend;
					rd[`IRQ_ST_ADDR_BIT] = st.addr_pend;
					rd[`IRQ_ST_CAUSE_LSB +: `IRQ_CAUSE_COUNT] = st.cause;
					rd[`IRQ_ST_VEC_LSB +: 8] = st.req.vector;
				end
				default: rd = '0;
			endcase
		end
		if (!st.ack) begin
			next_st.readdata = avs_req_in.read ? rd : 32'h0;
		end

		// Register writes at the ack edge
		if (wr) begin
			if (avs_req_in.address < `IRQ_PRIO_BASE + 8'(4 * `IRQ_PRIO_REG_COUNT)) begin
				for (int j = 0; j < `IRQ_NIBS_PER_REG; j++) begin
					src = int'(avs_req_in.address[7:2]) * `IRQ_NIBS_PER_REG + j;
					if (src < NSRC && avs_req_in.byteenable[j/2]) begin
						next_st.prio[src] =
							avs_req_in.writedata[j*`IRQ_NIB_W +: `IRQ_FIELD_W];
					end
				end
			end
			unique case (avs_req_in.address)
				`IRQ_FLAGS_LO: clr_lo = avs_req_in.writedata & mask;
				`IRQ_FLAGS_HI: clr_hi = avs_req_in.writedata & mask;
				`IRQ_ENABLE_LO: next_st.enables[31:0] =
					(st.enables[31:0] & ~mask) | (avs_req_in.writedata & mask);
				`IRQ_ENABLE_HI: next_st.enables[NSRC-1:32] =
					(st.enables[NSRC-1:32] & ~mask[HI_W-1:0])
					| (avs_req_in.writedata[HI_W-1:0] & mask[HI_W-1:0]);
				`IRQ_CTRL: if (avs_req_in.byteenable[0]) begin
					next_st.ctrl = avs_req_in.writedata[1:0];
				end
				`IRQ_STATUS: cause_clr = avs_req_in.writedata[`IRQ_ST_CAUSE_LSB +:
					`IRQ_CAUSE_COUNT] & mask[`IRQ_ST_CAUSE_LSB +: `IRQ_CAUSE_COUNT];
				default: ;
			endcase
		end

		// Sticky flags, an arriving event beats a clear
		next_st.flags = (st.flags & ~{clr_hi[HI_W-1:0], clr_lo}) | irq_event_in;

		// Error conditions that force a reset
		cause_set[`IRQ_CAUSE_WATCHDOG] = reset_err_in.watchdog_timeout;
		cause_set[`IRQ_CAUSE_UNINIT_W] = reset_err_in.uninit_w_pointer;
		cause_set[`IRQ_CAUSE_ILLEGAL] =
			reset_err_in.illegal_exec & ~reset_err_in.opcode_flushed;
		cause_set[`IRQ_CAUSE_BROWNOUT] = reset_err_in.brownout_reset;
		cause_set[`IRQ_CAUSE_LOCKOUT] = lockout;
		cause_set[`IRQ_CAUSE_CONFLICT] = math_cond & st.addr_pend & ~lockout;
		next_st.cause = (st.cause & ~cause_clr) | cause_set;
		next_st.force_reset = |cause_set;
		next_st.div_abort = trap_cond_in.div_by_zero;

		// Trap pending bits, a new condition beats the take
		if (take_trap) begin
			if (st.req.level == `IRQ_ADDR_TRAP_LEVEL) begin
				next_st.addr_pend = 1'b0;
			end else begin
				next_st.math_pend = 1'b0;
			end
		end
		if (math_cond && !lockout) begin
			next_st.math_pend = 1'b1;
		end
		if (addr_cond && !lockout) begin
			next_st.addr_pend = 1'b1;
		end
		// Presented only after the instruction boundary
		next_st.trap_ready = ((st.trap_ready & ~take_trap) | instr_done_in)
			& (next_st.math_pend | next_st.addr_pend);

		// Request to the core; traps first and never masked
		next_st.req = '0;
		next_st.win_src = win_src;
		if (st.entry == ENTRY_RUN) begin
			if (next_st.trap_ready) begin
				next_st.req.valid = 1'b1;
				next_st.req.is_trap = 1'b1;
				next_st.req.level = next_st.addr_pend ? `IRQ_ADDR_TRAP_LEVEL
					: `IRQ_MATH_TRAP_LEVEL;
				next_st.req.vector = next_st.addr_pend ? ADDR_TRAP_VECTOR
					: MATH_TRAP_VECTOR;
			end else if (win_found && {1'b0, win_level} > cpu_priority_bits_in) begin
				next_st.req.valid = 1'b1;
				next_st.req.level = {1'b0, win_level};
				next_st.req.vector = irq_vector(win_src);
			end
		end

		// Reset entry: jump word at zero, then its target
		next_st.start_valid = 1'b0;
		unique case (st.entry)
			ENTRY_OPCODE: begin
				next_st.fetch_req = 1'b1;
				next_st.fetch_addr = `IRQ_RESET_PC;
				if (st.fetch_req && fetch_valid_in) begin
					next_st.entry = ENTRY_TARGET;
					next_st.fetch_addr = `IRQ_RESET_PC + `IRQ_PROG_WORD_STEP;
				end
			end
			ENTRY_TARGET: begin
				if (fetch_valid_in) begin
					next_st.fetch_req = 1'b0;
					next_st.start_pc = fetch_data_in;
					next_st.start_valid = 1'b1;
					next_st.entry = ENTRY_RUN;
				end
			end
			ENTRY_RUN: ;
		endcase
	end

	// State register
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			st <= '0;
			st.prio <= {NSRC{`IRQ_PRIO_RESET}};
			st.ctrl <= `IRQ_CTRL_RESET;
			st.entry <= ENTRY_OPCODE;
			st.fetch_addr <= `IRQ_RESET_PC;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign avs_readdata_out = st.readdata;
	assign avs_waitrequest_out = !st.ack;
	assign core_req_out = st.req;
	assign force_reset_out = st.force_reset;
	assign div_abort_out = st.div_abort;
	assign fetch_req_out = st.fetch_req;
	assign fetch_addr_out = st.fetch_addr;
	assign start_valid_out = st.start_valid;
	assign start_pc_out = st.start_pc;

	// Checks
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);

	sequence s_both_traps;
		math_cond && addr_cond;
	endsequence

	sequence s_irq_shown;
		core_req_out.valid && !core_req_out.is_trap;
	endsequence

	sequence s_jump_fetched;
		fetch_req_out && fetch_valid_in && fetch_addr_out == `IRQ_RESET_PC;
	endsequence

	a_irq_above_cpu: assert property (s_irq_shown |->
		core_req_out.level > $past(cpu_priority_bits_in))
		else $error("interrupt shown at or below processor priority");
	a_level_zero_mute: assert property (s_irq_shown |->
		core_req_out.level != 4'h0 && st.prio[st.win_src] == core_req_out.level[2:0])
		else $error("level zero source interrupted");
	a_vector_plus_eight: assert property (s_irq_shown |->
		core_req_out.vector == {2'b00, st.win_src} + `IRQ_VECTOR_BASE)
		else $error("vector does not match source plus eight");
	a_level7_blocks: assert property ($past(cpu_priority_bits_in) == `IRQ_BLOCK_ALL_LEVEL
		&& core_req_out.valid |-> core_req_out.is_trap)
		else $error("interrupt passed at processor priority seven");
	a_trap_msb_set: assert property (core_req_out.valid && core_req_out.is_trap |->
		core_req_out.level[3])
		else $error("trap level without top bit");
	a_trap_after_done: assert property ($rose(core_req_out.valid && core_req_out.is_trap)
		|-> $past(instr_done_in))
		else $error("trap shown before instruction boundary");
	a_lockout_reset: assert property (s_both_traps |=>
		force_reset_out && st.cause[`IRQ_CAUSE_LOCKOUT])
		else $error("simultaneous traps did not force reset");
	a_flushed_quiet: assert property (reset_err_in.illegal_exec
		&& reset_err_in.opcode_flushed && !reset_err_in.watchdog_timeout
		&& !reset_err_in.uninit_w_pointer && !reset_err_in.brownout_reset
		&& !math_cond && !st.addr_pend |=> !force_reset_out)
		else $error("flushed opcode forced a reset");
	a_math_overflow: assert property (trap_cond_in.acc_ovf31
		&& !trap_cond_in.guard_bits_used && st.ctrl[`IRQ_CTRL_OVF31_EN] && !addr_cond
		|=> st.math_pend)
		else $error("enabled overflow missed the math trap");
	a_entry_target: assert property (s_jump_fetched ##1 !fetch_valid_in ##1 fetch_valid_in
		|=> start_valid_out && start_pc_out == $past(fetch_data_in))
		else $error("start address is not the jump target");
	a_nibble_top_zero: assert property (!avs_waitrequest_out && avs_req_in.read
		&& avs_req_in.address < 8'h38 |-> (avs_readdata_out & 32'hFFFF8888) == 32'h0)
		else $error("unimplemented priority bit read as one");

endmodule : irq_trap_priority_arbiter

`default_nettype wire

/* tb/core_model.sv */
// Core model: answers the reset-entry fetches and takes every shown trap.
// Assumes the arbiter's fetch and core request ports on one clock.
`default_nettype none

module core_model
	import irq_arb_pkg::*;
#(
	parameter logic [23:0] JUMP_WORD = 24'h040000, // Opcode content arbitrary
	parameter logic [23:0] TARGET = 24'h000200
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic fetch_req_in,
	input wire logic [23:0] fetch_addr_in,
	input wire core_req_t core_req_in,
	output logic fetch_valid_out,
	output logic [23:0] fetch_data_out,
	output logic take_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// Program words: jump at zero, its target in the next word
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			fetch_valid_out <= 1'b0;
			fetch_data_out <= 24'h000000;
		end else if (fetch_req_in && !fetch_valid_out) begin
			fetch_valid_out <= 1'b1;
			fetch_data_out <= (fetch_addr_in == 24'h000000) ? JUMP_WORD :
				((fetch_addr_in == 24'h000001) ? TARGET : ~TARGET);
		end else begin
			fetch_valid_out <= 1'b0;
			fetch_data_out <= ~fetch_data_out; // Stale word never looks valid
		end
	end

	// One take pulse for each trap shown
	always_ff @(posedge clock_in) begin
		take_out <= reset_n_in && core_req_in.valid && core_req_in.is_trap && !take_out;
	end
endmodule : core_model

`default_nettype wire

/* tb/irq_trap_priority_arbiter_bench.sv */
// Self-checking bench for the interrupt and trap priority arbiter.
// Assumes the core model on the fetch and request ports.
`default_nettype none
`include "irq_arb_consts.svh"

module irq_trap_priority_arbiter_bench
	import irq_arb_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [23:0] TARGET = 24'h000200;
	localparam logic [7:0] MATH_VEC = 8'h01;
	localparam logic [7:0] ADDR_VEC = 8'h02;
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	avalon_req_t avs_req = '0;
	logic [53:0] irq_event = '0;
	logic [3:0] cpu_prio = 4'h0;
	logic instr_done = 1'b0;
	trap_cond_t trap_cond = '0;
	reset_err_t reset_err = '0;
	logic [31:0] readdata;
	logic waitrequest;
	logic take;
	logic fetch_valid;
	logic [23:0] fetch_data;
	core_req_t core_req;
	logic force_reset;
	logic div_abort;
	logic fetch_req;
	logic start_valid;
	logic [23:0] fetch_addr;
	logic [23:0] start_pc;
	logic [31:0] rd;
	int mismatches = 0;
	int checked = 0;

	// Device under test and its core
	irq_trap_priority_arbiter #(.MATH_TRAP_VECTOR(MATH_VEC), .ADDR_TRAP_VECTOR(ADDR_VEC))
	i_irq_trap_priority_arbiter (.clock_in(clock_in), .reset_n_in(reset_n_in),
		.avs_req_in(avs_req), .avs_readdata_out(readdata), .avs_waitrequest_out(waitrequest),
		.irq_event_in(irq_event), .cpu_priority_bits_in(cpu_prio), .instr_done_in(instr_done),
		.take_in(take), .trap_cond_in(trap_cond), .reset_err_in(reset_err),
		.fetch_valid_in(fetch_valid), .fetch_data_in(fetch_data), .core_req_out(core_req),
		.force_reset_out(force_reset), .div_abort_out(div_abort), .fetch_req_out(fetch_req),
		.fetch_addr_out(fetch_addr), .start_valid_out(start_valid), .start_pc_out(start_pc));
	core_model #(.TARGET(TARGET)) i_core_model (.clock_in(clock_in), .reset_n_in(reset_n_in),
		.fetch_req_in(fetch_req), .fetch_addr_in(fetch_addr), .core_req_in(core_req),
		.fetch_valid_out(fetch_valid), .fetch_data_out(fetch_data), .take_out(take));

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		checked++;
		if (seen !== expected) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask : check

	// Verdict and end of run
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	// One Avalon cycle, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int n;
		n = 0;
		@(posedge clock_in);
		avs_req <= '{address: addr, read: !wr, write: wr, writedata: data, byteenable: 4'hF};
		do begin
			@(posedge clock_in);
			n++;
		end while (waitrequest !== 1'b0);
		rd = readdata;
		avs_req <= '0;
		check(n, 32'h2); // One wait cycle, answer at the second edge
	endtask : bus

	// Request shown to the core; only valid matters when idle
	task automatic req(input logic v, input logic t, input logic [3:0] l, input logic [7:0] vec);
		if (v)
			check({18'h0, core_req}, {18'h0, v, t, l, vec});
		else
			check({31'h0, core_req.valid}, 32'h0);
	endtask : req

	// One-cycle condition pulse, returns at the edge that shows its effect
	task automatic strike(input trap_cond_t c, input reset_err_t e, input logic [53:0] ev);
		@(posedge clock_in);
		trap_cond <= c;
		reset_err <= e;
		irq_event <= ev;
		@(posedge clock_in);
		trap_cond <= '0;
		reset_err <= '0;
		irq_event <= '0;
		@(posedge clock_in);
	endtask : strike

	// Instruction boundary pulse
	task automatic boundary();
		@(posedge clock_in);
		instr_done <= 1'b1;
		@(posedge clock_in);
		instr_done <= 1'b0;
		@(posedge clock_in);
	endtask : boundary

	// Reset entry: fetch from zero, start at the jump target
	task automatic test_entry();
		int n;
		n = 0;
		while (fetch_req !== 1'b1 && n < 40) begin
			@(posedge clock_in);
			n++;
		end
		check({31'h0, fetch_req}, 32'h1);
		check({8'h0, fetch_addr}, 32'h0);
		while (start_valid !== 1'b1 && n < 80) begin
			@(posedge clock_in);
			n++;
		end
		check({31'h0, start_valid}, 32'h1);
		check({8'h0, start_pc}, {8'h0, TARGET});
	endtask : test_entry

	// Priority nibbles keep three bits; unmapped reads zero
	task automatic test_regs();
		bus(1'b1, 8'h00, 32'hFFFFFFFF);
		bus(1'b0, 8'h00, 32'h0);
		check(rd, 32'h00007777);
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b0, 8'h60, 32'h0);
		check(rd, 32'h0);
	endtask : test_regs

	// Level first, then source number; strictly above processor priority
	task automatic test_arbitration();
		bus(1'b1, 8'h04, 32'h00000030);
		bus(1'b1, 8'h0C, 32'h00000003);
		bus(1'b1, 8'h28, 32'h00000005);
		bus(1'b1, 8'h48, 32'hFFFFFFFF);
		bus(1'b1, 8'h4C, 32'h003FFFFF);
		strike('0, '0, (54'h1 << 1) | (54'h1 << 5) | (54'h1 << 12));
		@(posedge clock_in); // Flag edge, then request edge
		req(1'b1, 1'b0, 4'h3, 8'h0D);
		strike('0, '0, 54'h1 << 40);
		@(posedge clock_in);
		req(1'b1, 1'b0, 4'h5, 8'h30);
		cpu_prio <= 4'h5;
		repeat (3) @(posedge clock_in);
		req(1'b0, 1'b0, 4'h0, 8'h00);
		cpu_prio <= 4'h2;
		repeat (3) @(posedge clock_in);
		req(1'b1, 1'b0, 4'h5, 8'h30);
		bus(1'b1, 8'h44, 32'h00000100);
		bus(1'b1, 8'h40, 32'h00000020);
		repeat (2) @(posedge clock_in);
		req(1'b1, 1'b0, 4'h3, 8'h14);
		cpu_prio <= 4'h3;
		repeat (3) @(posedge clock_in);
		req(1'b0, 1'b0, 4'h0, 8'h00);
		cpu_prio <= 4'h7;
	endtask : test_arbitration

	// Every math and address condition, two gated-off cases, then lockout
	task automatic test_traps();
		logic [11:0] conds [12] = '{12'h800, 12'h400, 12'h180, 12'h040, 12'h020, 12'h010,
			12'h008, 12'h004, 12'h002, 12'h001, 12'h600, 12'h100};
		bus(1'b1, 8'h50, 32'h00000003);
		for (int i = 0; i < 12; i++) begin
			strike(conds[i], '0, '0);
			check({31'h0, div_abort}, {31'h0, i == 0});
			repeat (2) @(posedge clock_in);
			req(1'b0, 1'b0, 4'h0, 8'h00);
			boundary();
			if (i < 4)
				req(1'b1, 1'b1, 4'hB, MATH_VEC);
			else if (i < 10)
				req(1'b1, 1'b1, 4'hC, ADDR_VEC);
			else
				req(1'b0, 1'b0, 4'h0, 8'h00);
			repeat (4) @(posedge clock_in);
		end
		strike(12'h820, '0, '0);
		check({31'h0, force_reset}, 32'h1);
		boundary();
		req(1'b0, 1'b0, 4'h0, 8'h00);
		bus(1'b0, 8'h54, 32'h0);
		check({26'h0, rd[13:8]}, 32'h10);
		bus(1'b1, 8'h54, 32'h00003F00);
	endtask : test_traps

	// Forced reset causes; a flushed opcode is harmless
	task automatic test_resets();
		logic [4:0] errs [5] = '{5'h10, 5'h08, 5'h04, 5'h06, 5'h01};
		logic [5:0] cause [5] = '{6'h01, 6'h02, 6'h04, 6'h00, 6'h08};
		for (int i = 0; i < 5; i++) begin
			strike('0, errs[i], '0);
			check({31'h0, force_reset}, {31'h0, cause[i] != 6'h00});
			bus(1'b0, 8'h54, 32'h0);
			check({26'h0, rd[13:8]}, {26'h0, cause[i]});
			bus(1'b1, 8'h54, 32'h00003F00);
		end
	endtask : test_resets

	// Clock
	always #20 clock_in = ~clock_in;

	// Main sequence
	initial begin
		repeat (12) @(posedge clock_in);
		check({31'h0, waitrequest}, 32'h1);
		reset_n_in <= 1'b1;
		test_entry();
		test_regs();
		test_arbitration();
		test_traps();
		test_resets();
		end_of_test();
	end

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clock_in);
		mismatches++;
		end_of_test();
	end
endmodule : irq_trap_priority_arbiter_bench

`default_nettype wire
